// File: hdl/arsx_regs.svh
// What this block does
// - Rotate right through carry shifts the addressed file register one place right, carry entering bit 7 and bit 0 leaving into carry.
// - Instructions with a destination bit write the accumulator when it is 0 and the addressed file register when it is 1.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears the power-down flag, sets the time-out flag and touches no other status bit.
// - After sleep the core sits in its low-power state with the oscillator halted.
// - Subtract from literal computes the literal minus the accumulator and puts it in the accumulator.
// - Both subtracts update carry, half carry and zero; carry is 0 when the accumulator is larger, half carry the same on the low nibble.
// - Subtract from register computes the file register minus the accumulator and writes the chosen destination.
// - Nibble swap exchanges the two halves of the file register, writes the chosen destination and leaves all flags alone.
// - Exclusive-OR with literal puts accumulator xor literal in the accumulator and changes only zero.
// - Exclusive-OR with register writes accumulator xor file register to the chosen destination and changes only zero.
`ifndef ARSX_REGS_SVH
`define ARSX_REGS_SVH
`define ARSX_W_RESET 8'h00
`define ARSX_STATUS_RESET 5'h18
`define ARSX_ST_C 0
`define ARSX_ST_HC 1
`define ARSX_ST_Z 2
`define ARSX_ST_PWDN 3
`define ARSX_ST_TMO 4
`define ARSX_FADDR_MAX 7'h7f
`define ARSX_WDOG_CLEAR 8'h00
`endif

// File: hdl/arsx_pkg.sv
package arsx_pkg;
	typedef enum logic [2:0] {
		ARSX_OP_NONE = 3'h0,
		ARSX_OP_ROTR = 3'h1,
		ARSX_OP_SUBL = 3'h2,
		ARSX_OP_SUBF = 3'h3,
		ARSX_OP_SWAP = 3'h4,
		ARSX_OP_XORL = 3'h5,
		ARSX_OP_XORF = 3'h6,
		ARSX_OP_SLEEP = 3'h7
	} arsx_op_e;
	typedef enum logic [1:0] {
		ARSX_RUN = 2'b01,
		ARSX_ASLEEP = 2'b10
	} arsx_pwr_e;
endpackage : arsx_pkg

// File: hdl/arsx_sub.sv
`timescale 1ns/1ps
// operand minus accumulator with carry and half carry
module arsx_sub (
	// operands
	input wire logic [7:0] a,
	input wire logic [7:0] w,
	// result
	output logic [7:0] diff,
	output logic carry,
	output logic half_carry
);
	logic [8:0] full;
	logic [4:0] low;
	assign full = {1'b0, a} + {1'b0, ~w} + 9'h001;
	assign low = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
	assign diff = full[7:0];
	assign carry = full[8];
	assign half_carry = low[4];
endmodule : arsx_sub

// File: hdl/arsx_power.sv
`timescale 1ns/1ps
`include "arsx_regs.svh"
// sleep state and watchdog clears
module arsx_power (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic sleep_req,
	input wire logic wake,
	// status
	output logic asleep,
	output logic wdog_clear
);
	arsx_pkg::arsx_pwr_e state_reg, state_next;
	logic clr_reg, clr_next;
	always_comb begin
		state_next = state_reg;
		clr_next = 1'b0;
		case (state_reg)
			arsx_pkg::ARSX_RUN: begin
				if (sleep_req) begin
					state_next = arsx_pkg::ARSX_ASLEEP;
					clr_next = 1'b1;
				end
			end
			arsx_pkg::ARSX_ASLEEP: begin
				if (wake) begin
					state_next = arsx_pkg::ARSX_RUN;
				end
			end
			default: state_next = arsx_pkg::ARSX_RUN;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= arsx_pkg::ARSX_RUN;
			clr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			clr_reg <= clr_next;
		end
	end
	assign asleep = (state_reg == arsx_pkg::ARSX_ASLEEP);
	assign wdog_clear = clr_reg;
endmodule : arsx_power

// File: hdl/arsx_alu.sv
`timescale 1ns/1ps
`include "arsx_regs.svh"
module arsx_alu (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// instruction
	input wire logic OP_VALID,
	input wire arsx_pkg::arsx_op_e OP,
	input wire logic [6:0] FADDR,
	input wire logic DEST,
	input wire logic [7:0] LITERAL,
	// file register read data for FADDR
	input wire logic [7:0] FDATA,
	// wake event from outside
	input wire logic WAKE,
	// file register write
	output logic FWR_EN,
	output logic [6:0] FWR_ADDR,
	output logic [7:0] FWR_DATA,
	// accumulator and status
	output logic [7:0] W,
	output logic CARRY,
	output logic HALF_CARRY,
	output logic ZERO,
	output logic POWER_DOWN_FLAG,
	output logic TIMEOUT_FLAG,
	// power control
	output logic WATCHDOG_CLEAR,
	output logic PRESCALER_CLEAR,
	output logic OSC_HALT,
	output logic ASLEEP
);
	logic [7:0] w_reg, w_next;
	logic [4:0] st_reg, st_next;
	logic fwe_reg, fwe_next;
	logic [6:0] fa_reg, fa_next;
	logic [7:0] fd_reg, fd_next;
	logic [7:0] sub_a, sub_d;
	logic sub_c, sub_hc;
	logic asleep_i, wdog_clr_i, go;

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	assign sub_a = (OP == arsx_pkg::ARSX_OP_SUBL) ? LITERAL : FDATA;

	arsx_sub u_sub (
		.a(sub_a),
		.w(w_reg),
		.diff(sub_d),
		.carry(sub_c),
		.half_carry(sub_hc)
	);

	assign go = OP_VALID && !asleep_i;

	arsx_power u_pwr (
		.clk(CLK),
		.rst_n(RST_N),
		.sleep_req(go && OP == arsx_pkg::ARSX_OP_SLEEP),
		.wake(WAKE),
		.asleep(asleep_i),
		.wdog_clear(wdog_clr_i)
	);

	always_comb begin
		logic [7:0] res;
		logic use_dest;
		res = 8'h00;
		use_dest = 1'b0;
		w_next = w_reg;
		st_next = st_reg;
		fwe_next = 1'b0;
		fa_next = fa_reg;
		fd_next = fd_reg;
		if (go) begin
			case (OP)
				arsx_pkg::ARSX_OP_ROTR: begin
					res = {st_reg[`ARSX_ST_C], FDATA[7:1]};
					st_next[`ARSX_ST_C] = FDATA[0];
					use_dest = 1'b1;
				end
				arsx_pkg::ARSX_OP_SUBL: begin
					w_next = sub_d;
					st_next[`ARSX_ST_C] = sub_c;
					st_next[`ARSX_ST_HC] = sub_hc;
					st_next[`ARSX_ST_Z] = is_zero(sub_d);
				end
				arsx_pkg::ARSX_OP_SUBF: begin
					res = sub_d;
					st_next[`ARSX_ST_C] = sub_c;
					st_next[`ARSX_ST_HC] = sub_hc;
					st_next[`ARSX_ST_Z] = is_zero(sub_d);
					use_dest = 1'b1;
				end
				arsx_pkg::ARSX_OP_SWAP: begin
					res = {FDATA[3:0], FDATA[7:4]};
					use_dest = 1'b1;
				end
				arsx_pkg::ARSX_OP_XORL: begin
					w_next = w_reg ^ LITERAL;
					st_next[`ARSX_ST_Z] = is_zero(w_reg ^ LITERAL);
				end
				arsx_pkg::ARSX_OP_XORF: begin
					res = w_reg ^ FDATA;
					st_next[`ARSX_ST_Z] = is_zero(res);
					use_dest = 1'b1;
				end
				arsx_pkg::ARSX_OP_SLEEP: begin
					st_next[`ARSX_ST_PWDN] = 1'b0;
					st_next[`ARSX_ST_TMO] = 1'b1;
				end
				default: begin
				end
			endcase
			if (use_dest) begin
				if (DEST) begin
					fwe_next = 1'b1;
					fa_next = FADDR;
					fd_next = res;
				end else begin
					w_next = res;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			w_reg <= `ARSX_W_RESET;
			st_reg <= `ARSX_STATUS_RESET;
			fwe_reg <= 1'b0;
			fa_reg <= 7'h00;
			fd_reg <= 8'h00;
		end else begin
			w_reg <= w_next;
			st_reg <= st_next;
			fwe_reg <= fwe_next;
			fa_reg <= fa_next;
			fd_reg <= fd_next;
		end
	end

	assign W = w_reg;
	assign CARRY = st_reg[`ARSX_ST_C];
	assign HALF_CARRY = st_reg[`ARSX_ST_HC];
	assign ZERO = st_reg[`ARSX_ST_Z];
	assign POWER_DOWN_FLAG = st_reg[`ARSX_ST_PWDN];
	assign TIMEOUT_FLAG = st_reg[`ARSX_ST_TMO];
	assign FWR_EN = fwe_reg;
	assign FWR_ADDR = fa_reg;
	assign FWR_DATA = fd_reg;
	assign WATCHDOG_CLEAR = wdog_clr_i;
	assign PRESCALER_CLEAR = wdog_clr_i;
	assign OSC_HALT = asleep_i;
	assign ASLEEP = asleep_i;

	// taken instruction of each kind
	logic iss_rot, iss_subl, iss_subf, iss_swap, iss_xorl, iss_xorf, iss_sleep;
	assign iss_rot = go && OP == arsx_pkg::ARSX_OP_ROTR;
	assign iss_subl = go && OP == arsx_pkg::ARSX_OP_SUBL;
	assign iss_subf = go && OP == arsx_pkg::ARSX_OP_SUBF;
	assign iss_swap = go && OP == arsx_pkg::ARSX_OP_SWAP;
	assign iss_xorl = go && OP == arsx_pkg::ARSX_OP_XORL;
	assign iss_xorf = go && OP == arsx_pkg::ARSX_OP_XORF;
	assign iss_sleep = go && OP == arsx_pkg::ARSX_OP_SLEEP;

	// rotate through carry
	rotate_result_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_rot && DEST |=> FWR_EN && FWR_DATA == {$past(CARRY), $past(FDATA[7:1])}
		&& CARRY == $past(FDATA[0]))
		else $error("rotate result wrong");

	rotate_wdest_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_rot && !DEST |=> !FWR_EN && W == {$past(CARRY), $past(FDATA[7:1])})
		else $error("rotate into accumulator wrong");

	rotate_flags_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_rot |=> $stable({HALF_CARRY, ZERO, POWER_DOWN_FLAG, TIMEOUT_FLAG}))
		else $error("rotate changed other flags");

	// destination select
	dest_select_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_swap && !DEST |=> !FWR_EN && W == {$past(FDATA[3:0]), $past(FDATA[7:4])})
		else $error("destination not accumulator");

	file_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_swap && DEST |=> FWR_EN && FWR_ADDR == $past(FADDR) && $stable(W))
		else $error("destination not file register");

	write_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
		FWR_EN |-> $past(go && DEST))
		else $error("file write without instruction");

	idle_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!go |=> !FWR_EN && $stable(W))
		else $error("idle cycle changed state");

	// sleep
	sleep_wdog_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_sleep |=> WATCHDOG_CLEAR && PRESCALER_CLEAR ##1 !WATCHDOG_CLEAR)
		else $error("watchdog not cleared once");

	clear_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
		WATCHDOG_CLEAR |-> $past(iss_sleep) && PRESCALER_CLEAR)
		else $error("watchdog cleared without sleep");

	sleep_flags_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_sleep |=> !POWER_DOWN_FLAG && TIMEOUT_FLAG && $stable(CARRY) && $stable(ZERO))
		else $error("sleep status wrong");

	sleep_halt_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_sleep ##1 !WAKE |=> OSC_HALT && ASLEEP)
		else $error("oscillator not halted");

	sleep_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
		ASLEEP && !WAKE |=> ASLEEP && OSC_HALT)
		else $error("left sleep without wake");

	asleep_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
		ASLEEP && OP_VALID |=> $stable(W) && !FWR_EN)
		else $error("instruction ran while asleep");

	// subtracts
	subl_value_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subl |=> W == 8'($past(LITERAL) - $past(W)))
		else $error("literal subtract wrong");

	subl_flags_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subl |=> CARRY == ($past(W) <= $past(LITERAL))
		&& HALF_CARRY == ($past(W[3:0]) <= $past(LITERAL[3:0])) && ZERO == (W == 8'h00))
		else $error("literal subtract flags wrong");

	sub_carry_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subf |=> CARRY == ($past(W) <= $past(FDATA))
		&& HALF_CARRY == ($past(W[3:0]) <= $past(FDATA[3:0])))
		else $error("subtract borrow wrong");

	subf_dest_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subf && DEST |=> FWR_EN && FWR_ADDR == $past(FADDR)
		&& FWR_DATA == 8'($past(FDATA) - $past(W)))
		else $error("register subtract wrong");

	subf_wdest_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subf && !DEST |=> !FWR_EN && W == 8'($past(FDATA) - $past(W)))
		else $error("register subtract into accumulator wrong");

	subf_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_subf && !DEST |=> ZERO == (W == 8'h00))
		else $error("subtract zero flag wrong");

	// nibble swap
	swap_flags_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_swap |=> $stable({CARRY, HALF_CARRY, ZERO, POWER_DOWN_FLAG, TIMEOUT_FLAG}))
		else $error("swap changed flags");

	swap_file_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_swap && DEST |=> FWR_DATA == {$past(FDATA[3:0]), $past(FDATA[7:4])})
		else $error("swap into file register wrong");

	// exclusive or
	xorl_value_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_xorl |=> W == ($past(W) ^ $past(LITERAL)) && !FWR_EN
		&& $stable({CARRY, HALF_CARRY, POWER_DOWN_FLAG, TIMEOUT_FLAG}))
		else $error("literal xor wrong");

	xor_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_xorl |=> ZERO == (W == 8'h00) && $stable(CARRY))
		else $error("xor zero flag wrong");

	xorf_file_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_xorf && DEST |=> FWR_EN && FWR_DATA == ($past(W) ^ $past(FDATA)) && $stable(W))
		else $error("register xor into file wrong");

	xorf_w_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_xorf && !DEST |=> W == ($past(W) ^ $past(FDATA))
		&& $stable({CARRY, HALF_CARRY, POWER_DOWN_FLAG, TIMEOUT_FLAG}))
		else $error("register xor into accumulator wrong");

	xorf_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
		iss_xorf && DEST |=> ZERO == (FWR_DATA == 8'h00))
		else $error("register xor zero flag wrong");

	// main scenarios
	cov_sleep_c: cover property (@(posedge CLK) disable iff (!RST_N) iss_sleep);
	cov_borrow_c: cover property (@(posedge CLK) disable iff (!RST_N) iss_subf ##1 !CARRY);
	cov_xorf_c: cover property (@(posedge CLK) disable iff (!RST_N) iss_xorf && DEST);
	cov_rotate_c: cover property (@(posedge CLK) disable iff (!RST_N) iss_rot && DEST);
	cov_wake_c: cover property (@(posedge CLK) disable iff (!RST_N) ASLEEP && WAKE);
endmodule : arsx_alu

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk;
	logic rst_n;
	logic op_valid;
	arsx_pkg::arsx_op_e op_code;
	logic [6:0] faddr;
	logic dest;
	logic [7:0] literal;
	logic [7:0] fdata;
	logic wake;
	logic fwr_en;
	logic [6:0] fwr_addr;
	logic [7:0] fwr_data;
	logic [7:0] w;
	logic carry, half_carry, zero, pwdn, tmo, wdog_clr, pre_clr, osc_halt, asleep;
	int fail_count;
	int n_tests;

	arsx_alu uut (.CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP(op_code), .FADDR(faddr), .DEST(dest),
		.LITERAL(literal), .FDATA(fdata), .WAKE(wake), .FWR_EN(fwr_en), .FWR_ADDR(fwr_addr), .FWR_DATA(fwr_data),
		.W(w), .CARRY(carry), .HALF_CARRY(half_carry), .ZERO(zero), .POWER_DOWN_FLAG(pwdn), .TIMEOUT_FLAG(tmo),
		.WATCHDOG_CLEAR(wdog_clr), .PRESCALER_CLEAR(pre_clr), .OSC_HALT(osc_halt), .ASLEEP(asleep));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// issue one instruction, then check accumulator and {carry, half carry, zero, power down, time out}
	task run(input arsx_pkg::arsx_op_e e, input logic [6:0] fa, input logic d, input logic [7:0] k,
		input logic [7:0] fd, input logic [7:0] ew, input logic [4:0] es);
		op_valid = 1'b1;
		op_code = e;
		faddr = fa;
		dest = d;
		literal = k;
		fdata = fd;
		@(posedge clk);
		#1;
		chk("w", ew, w);
		chk("status", {3'h0, es}, {3'h0, carry, half_carry, zero, pwdn, tmo});
	endtask : run

	// ef = {fwr_en, fwr_addr}
	task ckf(input logic [7:0] ef, input logic [7:0] ed);
		chk("fwr_en", {7'h0, ef[7]}, {7'h0, fwr_en});
		if (ef[7]) begin
			chk("fwr_addr", ef, {fwr_en, fwr_addr});
			chk("fwr_data", ed, fwr_data);
		end
	endtask : ckf

	task ckp(input logic [3:0] e);
		chk("power", {4'h0, e}, {4'h0, wdog_clr, pre_clr, osc_halt, asleep});
	endtask : ckp

	task idle;
		op_valid = 1'b0;
		@(posedge clk);
		#1;
	endtask : idle

	task do_reset(input int n);
		rst_n = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("w", 8'h00, w);
		chk("status", 8'h03, {3'h0, carry, half_carry, zero, pwdn, tmo});
		ckf(8'h00, 8'h00);
		ckp(4'h0);
	endtask : do_reset

	task t_sub_lit;
		run(arsx_pkg::ARSX_OP_XORL, 7'h00, 1'b0, 8'h3c, 8'h00, 8'h3c, 5'h03);
		run(arsx_pkg::ARSX_OP_SUBL, 7'h00, 1'b0, 8'h3c, 8'h00, 8'h00, 5'h1f);
		run(arsx_pkg::ARSX_OP_XORL, 7'h00, 1'b0, 8'h25, 8'h00, 8'h25, 5'h1b);
		run(arsx_pkg::ARSX_OP_SUBL, 7'h00, 1'b0, 8'h13, 8'h00, 8'hee, 5'h03);
		run(arsx_pkg::ARSX_OP_SUBL, 7'h00, 1'b0, 8'hfe, 8'h00, 8'h10, 5'h1b);
		idle();
		chk("w", 8'h10, w);
	endtask : t_sub_lit

	task t_sub_reg;
		run(arsx_pkg::ARSX_OP_SUBF, 7'h7f, 1'b1, 8'h00, 8'h13, 8'h10, 5'h1b);
		ckf(8'hff, 8'h03);
		run(arsx_pkg::ARSX_OP_SUBF, 7'h00, 1'b0, 8'h00, 8'h0f, 8'hff, 5'h0b);
		ckf(8'h00, 8'h00);
		idle();
	endtask : t_sub_reg

	task t_rotate;
		run(arsx_pkg::ARSX_OP_ROTR, 7'h05, 1'b0, 8'h00, 8'h81, 8'h40, 5'h1b);
		run(arsx_pkg::ARSX_OP_ROTR, 7'h06, 1'b1, 8'h00, 8'h02, 8'h40, 5'h0b);
		ckf(8'h86, 8'h81);
		idle();
	endtask : t_rotate

	task t_swap;
		run(arsx_pkg::ARSX_OP_SUBL, 7'h00, 1'b0, 8'h40, 8'h00, 8'h00, 5'h1f);
		run(arsx_pkg::ARSX_OP_SWAP, 7'h10, 1'b0, 8'h00, 8'ha5, 8'h5a, 5'h1f);
		run(arsx_pkg::ARSX_OP_SWAP, 7'h11, 1'b1, 8'h00, 8'h0f, 8'h5a, 5'h1f);
		ckf(8'h91, 8'hf0);
		idle();
	endtask : t_swap

	task t_xor;
		run(arsx_pkg::ARSX_OP_XORF, 7'h20, 1'b0, 8'h00, 8'h0f, 8'h55, 5'h1b);
		run(arsx_pkg::ARSX_OP_XORF, 7'h21, 1'b1, 8'h00, 8'h55, 8'h55, 5'h1f);
		ckf(8'ha1, 8'h00);
		idle();
	endtask : t_xor

	task t_sleep;
		run(arsx_pkg::ARSX_OP_NONE, 7'h00, 1'b1, 8'hff, 8'h00, 8'h55, 5'h1f);
		ckf(8'h00, 8'h00);
		run(arsx_pkg::ARSX_OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00, 8'h55, 5'h1d);
		ckp(4'hf);
		run(arsx_pkg::ARSX_OP_XORL, 7'h00, 1'b0, 8'hff, 8'h00, 8'h55, 5'h1d);
		ckp(4'h3);
		op_valid = 1'b0;
		wake = 1'b1;
		@(posedge clk);
		#1;
		wake = 1'b0;
		ckp(4'h0);
		run(arsx_pkg::ARSX_OP_XORL, 7'h00, 1'b0, 8'h55, 8'h00, 8'h00, 5'h1d);
		idle();
	endtask : t_sleep

	task complete_run;
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		#20000;
		fail_count++;
		complete_run();
	end

	initial begin
		fail_count = 0;
		n_tests = 0;
		op_valid = 1'b0;
		op_code = arsx_pkg::ARSX_OP_NONE;
		faddr = 7'h00;
		dest = 1'b0;
		literal = 8'h00;
		fdata = 8'h00;
		wake = 1'b0;
		do_reset(5);
		t_sub_lit();
		t_sub_reg();
		t_rotate();
		t_swap();
		t_xor();
		t_sleep();
		do_reset(1);
		complete_run();
	end
endmodule : tb_top
